// ==== core/pdca_pkg.sv ====
/*
 * Constants and carrier types for the peripheral DMA
 * channels and the fixed-priority RAM matrix they compete in.
 * Assumes one 200 MHz clock and byte-wide single-beat RAM accesses.
 */
// What this block and the software that drives it must do
// RULE1: Channels master RAM only, never flash
// RULE2: Separate reader and memory_write_channel channels, own registers
// RULE3: Reader fetches exactly max count bytes
// RULE4: Memory_write_channel never exceeds max count, may stop early
// RULE5: Byte-granular pointers and counts
// RULE6: Transferred transferred_byte_count readable after completion
// RULE7: Software keeps memory_write_channel count within buffer
// RULE8: Software loads valid pointer before start
// RULE9: Bad pointer gives observable error flag
// RULE10: Lost arbitration stalls or drops, fixed
// RULE11: List mode only where selector exists
// RULE12: List items contiguous, no next pointer
// RULE13: Item size equals max count
// RULE14: Matrix lets different slaves run parallel
// RULE15: Highest-priority requester granted first
// RULE16: Lower masters stall until transaction done
// RULE17: Paused higher master lends slave temporarily
// RULE18: Same-priority masters share one exclusive slot
// RULE19: Fixed priority order, processor highest
// RULE20: Masters are processor and DMA peripherals
// RULE21: Software avoids exhausting shared slave bandwidth
// RULE22: Unbuffered low-priority masters may lose data
// RULE23: List item n starts at pointer plus n*count
// RULE24: End on count or peripheral end, latch transferred_byte_count
package pdca_pkg;

    localparam int NM       = 4;
    localparam int NS       = 2;
    localparam int BANK_BIT = 17;

    localparam logic [1:0] M_CPU = 2'h0;
    localparam logic [1:0] M_RD  = 2'h1;
    localparam logic [1:0] M_WR  = 2'h2;
    localparam logic [1:0] M_LOW = 2'h3;

    localparam logic [31:0] RAM_BASE = 32'h2000_0000;
    localparam logic [31:0] RAM_SIZE = 32'h0004_0000;

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STAT   = 8'h04;
    localparam logic [7:0] OFS_RD_PTR = 8'h08;
    localparam logic [7:0] OFS_RD_MAX = 8'h0C;
    localparam logic [7:0] OFS_RD_AMT = 8'h10;
    localparam logic [7:0] OFS_RD_LST = 8'h14;
    localparam logic [7:0] OFS_WR_PTR = 8'h18;
    localparam logic [7:0] OFS_WR_MAX = 8'h1C;
    localparam logic [7:0] OFS_WR_AMT = 8'h20;

    localparam int CTRL_RD_START = 0;
    localparam int CTRL_WR_START = 1;
    localparam int ST_RD_BUSY = 0;
    localparam int ST_WR_BUSY = 1;
    localparam int ST_RD_DONE = 2;
    localparam int ST_WR_DONE = 3;
    localparam int ST_RD_ERR  = 4;
    localparam int ST_WR_ERR  = 5;
    localparam int ST_WR_DROP = 6;

    localparam logic [31:0] PTR_RST = 32'h0000_0000;
    localparam logic [15:0] CNT_RST = 16'h0000;

    typedef struct packed {
        logic        valid;
        logic        we;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } pdca_req_t;

endpackage : pdca_pkg

// ==== core/pdca_top.sv ====
/*
 * One DMA-capable peripheral (reader channel with list mode, memory_write_channel
 * channel) plus the fixed-priority matrix to the RAM slave banks.
 * Assumes RAM slaves hold ram_req until they raise ram_ready and that
 * outside masters hold their request until ext_done or ext_err.
 */
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module pdca_top #(
    parameter bit WR_DROPS = 1'b0                 // Memory_write_channel drops, not stalls
) (
    input  wire logic                   clk,       // System clock
    input  wire logic                   sys_rst,   // Async reset
    input  wire logic [7:0]             reg_addr,  // Register address
    input  wire logic [31:0]            reg_wdata, // Register write data
    input  wire logic                   reg_wr,    // Write strobe
    input  wire logic                   reg_rd,    // Read strobe
    output logic      [31:0]            reg_rdata, // Read data
    input  wire pdca_pkg::pdca_req_t [1:0] ext_req,  // Processor, low master
    output logic      [1:0]             ext_done,  // Outside access done
    output logic      [1:0]             ext_err,   // Outside access refused
    output logic      [1:0][7:0]        ext_rdata, // Outside read data
    output pdca_pkg::pdca_req_t [1:0]   ram_req,   // Per-bank access
    input  wire logic [1:0]             ram_ready, // Per-bank completion
    input  wire logic [1:0][7:0]        ram_rdata, // Per-bank read data
    output logic      [7:0]             rd_data,   // Byte to peripheral
    output logic                        rd_valid,  // Byte available
    input  wire logic                   rd_ready,  // Peripheral takes byte
    input  wire logic [7:0]             wr_data,   // Byte from peripheral
    input  wire logic                   wr_valid,  // Byte offered
    output logic                        wr_ready,  // Channel takes byte
    input  wire logic                   wr_end     // Peripheral ends early
);
    localparam int NM = pdca_pkg::NM;
    localparam int NS = pdca_pkg::NS;

    typedef enum logic [1:0] {
        PDCA_RD_IDLE = 2'b00,
        PDCA_RD_REQ  = 2'b01,
        PDCA_RD_OUT  = 2'b10
    } pdca_rd_t;

    typedef enum logic [1:0] {
        PDCA_WR_IDLE = 2'b00,
        PDCA_WR_WAIT = 2'b01,
        PDCA_WR_REQ  = 2'b10
    } pdca_wr_t;

    pdca_pkg::pdca_req_t [NM-1:0] mreq;
    pdca_pkg::pdca_req_t          rd_req_reg;
    pdca_pkg::pdca_req_t          wr_req_reg;
    pdca_pkg::pdca_req_t [NS-1:0] ram_req_reg;
    logic [NS-1:0]       busy_reg;
    logic [NS-1:0][1:0]  owner_reg;
    logic [NM-1:0]       in_ram;
    logic [NM-1:0]       inflight;
    logic [NM-1:0]       done;
    logic [NM-1:0]       err;
    logic [NM-1:0]       hold_reg;
    logic [NM-1:0][7:0]  mrdata;

    // Each slot stands for one exclusive same-priority group
    assign mreq[pdca_pkg::M_CPU] = ext_req[0];           // RULE18 RULE20
    assign mreq[pdca_pkg::M_RD]  = rd_req_reg;
    assign mreq[pdca_pkg::M_WR]  = wr_req_reg;
    assign mreq[pdca_pkg::M_LOW] = ext_req[1];

    genvar m, s;
    generate
        for (m = 0; m < NM; m++) begin : g_mst
            assign in_ram[m] =
                (mreq[m].addr >= pdca_pkg::RAM_BASE) &&
                (mreq[m].addr - pdca_pkg::RAM_BASE
                    < pdca_pkg::RAM_SIZE);                 // RULE1
            assign err[m] = mreq[m].valid && !in_ram[m]
                && !hold_reg[m];                           // RULE9
        end
    endgenerate

    always_comb begin
        inflight = '0;
        done     = '0;
        mrdata   = '0;
        for (int i = 0; i < NS; i++) begin
            inflight[owner_reg[i]] |= busy_reg[i];
            if (busy_reg[i] && ram_ready[i]) begin
                done[owner_reg[i]]   = 1'b1;
                mrdata[owner_reg[i]] = ram_rdata[i];
            end
        end
    end

    // Finished masters sit out one cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_reg  <= '0;
            ext_done  <= '0;
            ext_err   <= '0;
            ext_rdata <= '0;
        end else begin
            hold_reg  <= done | err;
            ext_done  <= {done[pdca_pkg::M_LOW], done[pdca_pkg::M_CPU]};
            ext_err   <= {err[pdca_pkg::M_LOW], err[pdca_pkg::M_CPU]};
            ext_rdata <= {mrdata[pdca_pkg::M_LOW],
                          mrdata[pdca_pkg::M_CPU]};
        end
    end

    // One arbiter per bank; banks run independently
    generate
        for (s = 0; s < NS; s++) begin : g_slv           // RULE14
            logic [NM-1:0] cand;
            logic [1:0]    win;
            for (m = 0; m < NM; m++) begin : g_cand
                assign cand[m] = mreq[m].valid && in_ram[m] && !hold_reg[m]
                    && !inflight[m]
                    && (mreq[m].addr[pdca_pkg::BANK_BIT] == s[0]);
            end
            // Lowest index is highest priority, re-decided per beat
            always_comb begin
                win = 2'h0;
                for (int i = NM - 1; i >= 0; i--) begin
                    if (cand[i]) begin
                        win = i[1:0];                      // RULE15 RULE19
                    end
                end
            end
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    busy_reg[s]    <= 1'b0;
                    owner_reg[s]   <= 2'h0;
                    ram_req_reg[s] <= '0;
                end else if (busy_reg[s]) begin
                    if (ram_ready[s]) begin                // RULE16
                        busy_reg[s]          <= 1'b0;
                        ram_req_reg[s].valid <= 1'b0;
                    end
                end else if (|cand) begin                  // RULE17
                    busy_reg[s]    <= 1'b1;
                    owner_reg[s]   <= win;
                    ram_req_reg[s] <= mreq[win];
                end
            end
        end
    endgenerate

    assign ram_req = ram_req_reg;

    logic [31:0] rd_ptr_reg;
    logic [31:0] rd_base_reg;
    logic [15:0] rd_max_reg;
    logic [15:0] rd_cnt_reg;
    logic [15:0] rd_amt_reg;
    logic        rd_list_reg;
    logic [31:0] wr_ptr_reg;
    logic [15:0] wr_max_reg;
    logic [15:0] wr_cnt_reg;
    logic [15:0] wr_amt_reg;
    logic [6:0]  stat_reg;
    logic [31:0] rdata_reg;
    pdca_rd_t    rd_st_reg;
    pdca_wr_t    wr_st_reg;

    wire wr_ctrl = reg_wr && reg_addr == pdca_pkg::OFS_CTRL;
    wire rd_go   = wr_ctrl && reg_wdata[pdca_pkg::CTRL_RD_START]
                   && rd_st_reg == PDCA_RD_IDLE;
    wire wr_go   = wr_ctrl && reg_wdata[pdca_pkg::CTRL_WR_START]
                   && wr_st_reg == PDCA_WR_IDLE;
    wire stat_w  = reg_wr && reg_addr == pdca_pkg::OFS_STAT;

    wire [15:0] rd_cnt_inc = rd_cnt_reg + 16'h1;
    wire        rd_take    = rd_st_reg == PDCA_RD_OUT && rd_valid
                             && rd_ready;
    wire        rd_last    = rd_cnt_inc == rd_max_reg;
    wire        rd_fin     = (rd_take && rd_last) || (rd_go
                             && rd_max_reg == pdca_pkg::CNT_RST);
    wire        rd_fail    = err[pdca_pkg::M_RD];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_st_reg  <= PDCA_RD_IDLE;
            rd_req_reg <= '0;
            rd_cnt_reg <= pdca_pkg::CNT_RST;
            rd_amt_reg <= pdca_pkg::CNT_RST;
            rd_data    <= 8'h00;
            rd_valid   <= 1'b0;
        end else begin
            case (rd_st_reg)
                PDCA_RD_IDLE: begin
                    if (rd_go && rd_max_reg != pdca_pkg::CNT_RST) begin
                        rd_st_reg        <= PDCA_RD_REQ;
                        rd_cnt_reg       <= pdca_pkg::CNT_RST;
                        rd_req_reg.valid <= 1'b1;
                        rd_req_reg.we    <= 1'b0;
                        rd_req_reg.addr  <= rd_base_reg;   // RULE5
                    end else if (rd_go) begin
                        rd_amt_reg <= pdca_pkg::CNT_RST;
                    end
                end
                PDCA_RD_REQ: begin
                    if (rd_fail) begin
                        rd_st_reg        <= PDCA_RD_IDLE;
                        rd_req_reg.valid <= 1'b0;
                        rd_amt_reg       <= rd_cnt_reg;    // RULE6
                    end else if (done[pdca_pkg::M_RD]) begin
                        rd_st_reg        <= PDCA_RD_OUT;
                        rd_req_reg.valid <= 1'b0;
                        rd_data          <= mrdata[pdca_pkg::M_RD];
                        rd_valid         <= 1'b1;
                    end
                end
                PDCA_RD_OUT: begin
                    if (rd_take) begin
                        rd_valid   <= 1'b0;
                        rd_cnt_reg <= rd_cnt_inc;
                        if (rd_last) begin                 // RULE3 RULE24
                            rd_st_reg  <= PDCA_RD_IDLE;
                            rd_amt_reg <= rd_cnt_inc;      // RULE6
                        end else begin
                            rd_st_reg        <= PDCA_RD_REQ;
                            rd_req_reg.valid <= 1'b1;
                            rd_req_reg.addr  <= rd_base_reg
                                + {16'h0, rd_cnt_inc};
                        end
                    end
                end
                default: rd_st_reg <= PDCA_RD_IDLE;
            endcase
        end
    end

    // Item base steps by one item per finished list transfer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_base_reg <= pdca_pkg::PTR_RST;
        end else if (reg_wr && reg_addr == pdca_pkg::OFS_RD_PTR) begin
            rd_base_reg <= reg_wdata;
        end else if (rd_take && rd_last && rd_list_reg) begin
            rd_base_reg <= rd_base_reg
                + {16'h0, rd_max_reg};             // RULE12 RULE13 RULE23
        end
    end

    wire [15:0] wr_cnt_inc = wr_cnt_reg + 16'h1;
    wire        wr_take    = wr_st_reg == PDCA_WR_WAIT && wr_ready
                             && wr_valid;
    wire        wr_lost    = WR_DROPS && wr_st_reg == PDCA_WR_REQ
                             && wr_valid;
    wire        wr_wdone   = done[pdca_pkg::M_WR];
    wire        wr_fail    = err[pdca_pkg::M_WR];
    logic       wr_endp_reg;
    wire        wr_stop    = wr_endp_reg || wr_end;
    wire        wr_fin     = (wr_wdone && (wr_cnt_inc == wr_max_reg
                             || wr_stop))
                             || (wr_st_reg == PDCA_WR_WAIT && wr_end
                             && !wr_take)
                             || (wr_go && wr_max_reg == pdca_pkg::CNT_RST);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_st_reg   <= PDCA_WR_IDLE;
            wr_req_reg  <= '0;
            wr_cnt_reg  <= pdca_pkg::CNT_RST;
            wr_amt_reg  <= pdca_pkg::CNT_RST;
            wr_ready    <= 1'b0;
            wr_endp_reg <= 1'b0;
        end else begin
            case (wr_st_reg)
                PDCA_WR_IDLE: begin
                    wr_endp_reg <= 1'b0;
                    if (wr_go && wr_max_reg != pdca_pkg::CNT_RST) begin
                        wr_st_reg  <= PDCA_WR_WAIT;
                        wr_cnt_reg <= pdca_pkg::CNT_RST;
                        wr_ready   <= 1'b1;
                    end else if (wr_go) begin
                        wr_amt_reg <= pdca_pkg::CNT_RST;
                    end
                end
                PDCA_WR_WAIT: begin
                    if (wr_take) begin
                        wr_st_reg        <= PDCA_WR_REQ;
                        wr_ready         <= WR_DROPS;      // RULE10
                        wr_endp_reg      <= wr_end;
                        wr_req_reg.valid <= 1'b1;
                        wr_req_reg.we    <= 1'b1;
                        wr_req_reg.wdata <= wr_data;
                        wr_req_reg.addr  <= wr_ptr_reg
                            + {16'h0, wr_cnt_reg};         // RULE5
                    end else if (wr_end) begin             // RULE24
                        wr_st_reg  <= PDCA_WR_IDLE;
                        wr_ready   <= 1'b0;
                        wr_amt_reg <= wr_cnt_reg;
                    end
                end
                PDCA_WR_REQ: begin
                    if (wr_end) begin
                        wr_endp_reg <= 1'b1;
                    end
                    if (wr_fail) begin
                        wr_st_reg        <= PDCA_WR_IDLE;
                        wr_ready         <= 1'b0;
                        wr_req_reg.valid <= 1'b0;
                        wr_amt_reg       <= wr_cnt_reg;    // RULE6
                    end else if (wr_wdone) begin
                        wr_req_reg.valid <= 1'b0;
                        wr_cnt_reg       <= wr_cnt_inc;
                        if (wr_fin) begin                  // RULE4 RULE24
                            wr_st_reg  <= PDCA_WR_IDLE;
                            wr_ready   <= 1'b0;
                            wr_amt_reg <= wr_cnt_inc;      // RULE6
                        end else begin
                            wr_st_reg <= PDCA_WR_WAIT;
                            wr_ready  <= 1'b1;
                        end
                    end
                end
                default: wr_st_reg <= PDCA_WR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_ptr_reg  <= pdca_pkg::PTR_RST;
            rd_max_reg  <= pdca_pkg::CNT_RST;
            rd_list_reg <= 1'b0;
            wr_ptr_reg  <= pdca_pkg::PTR_RST;
            wr_max_reg  <= pdca_pkg::CNT_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                pdca_pkg::OFS_RD_PTR: rd_ptr_reg  <= reg_wdata; // RULE2
                pdca_pkg::OFS_RD_MAX: rd_max_reg  <= reg_wdata[15:0];
                pdca_pkg::OFS_RD_LST: rd_list_reg <= reg_wdata[0]; // RULE11
                pdca_pkg::OFS_WR_PTR: wr_ptr_reg  <= reg_wdata;
                pdca_pkg::OFS_WR_MAX: wr_max_reg  <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // Sticky flags: a set in the clearing cycle survives
    wire [6:0] stat_set = {wr_lost, wr_fail, rd_fail, wr_fin, rd_fin,
                           2'b00};                         // RULE9 RULE22
    wire [6:0] stat_clr = stat_w ? reg_wdata[6:0] : 7'h00;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_reg <= 7'h00;
        end else begin
            stat_reg <= (stat_reg & ~stat_clr) | stat_set;
        end
    end

    wire [6:0] stat_view = {stat_reg[6:2],
                            wr_st_reg != PDCA_WR_IDLE,
                            rd_st_reg != PDCA_RD_IDLE};

    logic [31:0] rmux;
    always_comb begin
        case (reg_addr)
            pdca_pkg::OFS_STAT:   rmux = {25'h0, stat_view};
            pdca_pkg::OFS_RD_PTR: rmux = rd_ptr_reg;
            pdca_pkg::OFS_RD_MAX: rmux = {16'h0, rd_max_reg};
            pdca_pkg::OFS_RD_AMT: rmux = {16'h0, rd_amt_reg};
            pdca_pkg::OFS_RD_LST: rmux = {31'h0, rd_list_reg};
            pdca_pkg::OFS_WR_PTR: rmux = wr_ptr_reg;
            pdca_pkg::OFS_WR_MAX: rmux = {16'h0, wr_max_reg};
            pdca_pkg::OFS_WR_AMT: rmux = {16'h0, wr_amt_reg};
            default:              rmux = 32'h0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= reg_rd ? rmux : 32'h0;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule : pdca_top

// ==== tb/pdca_ram_model.sv ====
/* RAM bank model on the matrix side of the DMA block.
   Assumes each request holds until the bank answers ready. */
`timescale 1ns/1ps
module pdca_ram_model (
    input  wire logic                      clk,   // Clock
    input  wire logic                      slow,  // Add wait states
    input  wire pdca_pkg::pdca_req_t [1:0] req,   // Bank requests
    output logic      [1:0]                ready, // Done pulse
    output logic      [1:0][7:0]           rdata  // Read data
);
    logic [7:0] mem [logic [31:0]];
    logic [1:0] cnt [2] = '{2'h0, 2'h0};
    logic       go;
    initial {ready, rdata} = '0;
    // Banks answer independently; data toggles outside an answer
    always @(posedge clk) begin
        for (int s = 0; s < 2; s++) begin
            go = req[s].valid && !ready[s] && cnt[s] >= {slow, 1'b0};
            ready[s] <= go;
            cnt[s] <= req[s].valid && !ready[s] ? cnt[s] + 2'h1 : 2'h0;
            rdata[s] <= !go ? ~rdata[s] : mem.exists(req[s].addr) ?
                mem[req[s].addr] : req[s].addr[7:0] ^ 8'hA5;
            if (go && req[s].we) mem[req[s].addr] = req[s].wdata;
        end
    end
endmodule : pdca_ram_model

// ==== tb/pdca_chk.sv ====
/* Port checks on the DMA channels and the RAM matrix.
   Assumes one clock and inputs held low during reset. */
`timescale 1ns/1ps
module pdca_chk #(
    parameter bit WR_DROPS = 1'b0                   // Memory_write_channel drop mode
) (
    input wire logic                      clk,       // Clock
    input wire logic                      sys_rst,   // Reset
    input wire logic                      reg_rd,    // Read strobe
    input wire logic [31:0]               reg_rdata, // Read data
    input wire pdca_pkg::pdca_req_t [1:0] ext_req,   // Outside masters
    input wire logic [1:0]                ext_done,  // Outside done
    input wire logic [1:0]                ext_err,   // Outside refused
    input wire pdca_pkg::pdca_req_t [1:0] ram_req,   // Bank access
    input wire logic [1:0]                ram_ready, // Bank done
    input wire logic [7:0]                rd_data,   // Byte out
    input wire logic                      rd_valid,  // Byte ready
    input wire logic                      rd_ready,  // Byte taken
    input wire logic                      wr_valid,  // Byte offered
    input wire logic                      wr_ready   // Byte accepted
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_bank_range;
        (ram_req[0].valid |-> ram_req[0].addr[31:17] == 15'h1000) and
        (ram_req[1].valid |-> ram_req[1].addr[31:17] == 15'h1001);
    endproperty
    a_bank_range: assert property (p_bank_range) else $error("bank range");
    property p_ram_hold;
        ram_req[0].valid && !ram_ready[0] |=>
            ram_req[0].valid && $stable(ram_req[0].addr);
    endproperty
    a_ram_hold: assert property (p_ram_hold) else $error("bank hold");
    property p_cpu_first;
        $rose(ram_req[0].valid) && $past(ext_req[0].valid) &&
        !$past(ext_req[0].valid, 2) && $past(ext_req[0].addr[31:17]) == 15'h1000
        |-> ram_req[0].addr == $past(ext_req[0].addr);
    endproperty
    a_cpu_first: assert property (p_cpu_first) else $error("cpu lost");
    property p_ext_err;
        ext_err[0] |-> $past(ext_req[0].addr[31:18]) != 14'h0800;
    endproperty
    a_ext_err: assert property (p_ext_err) else $error("bad refusal");
    property p_done_src;
        ext_done[0] |-> $past(ram_ready[0] || ram_ready[1]);
    endproperty
    a_done_src: assert property (p_done_src) else $error("early done");
    property p_rd_hold;
        rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("byte lost");
    property p_wr_stall;
        !WR_DROPS && wr_valid && wr_ready |=> !wr_ready;
    endproperty
    a_wr_stall: assert property (p_wr_stall) else $error("no stall");
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray data");
endmodule : pdca_chk
bind pdca_top pdca_chk #(.WR_DROPS(WR_DROPS)) pdca_chk_inst (.clk, .sys_rst,
    .reg_rd, .reg_rdata, .ext_req, .ext_done, .ext_err, .ram_req, .ram_ready,
    .rd_data, .rd_valid, .rd_ready, .wr_valid, .wr_ready);

// ==== tb/tb.sv ====
/* Self-checking bench for pdca_top with a RAM bank model.
   Assumes memory_write_channel stall mode and no traffic during reset. */
`timescale 1ns/1ps
module tb;
    typedef struct {logic [7:0] a; logic [31:0] d, e;} pdca_row_t;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, wr_data = 8'h00, rd_data, x0, x1;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    pdca_pkg::pdca_req_t [1:0] ext_req = '0, ram_req;
    logic [1:0] ext_done, ext_err, ram_ready, s0, s1;
    logic [1:0][7:0] ext_rdata, ram_rdata;
    logic rd_valid, rd_ready = 1'b0, wr_valid = 1'b0, wr_ready;
    logic wr_end = 1'b0, slow = 1'b0;
    logic [7:0] rd_q[$];
    int n_errors = 0, total_checks = 0, cyc = 0, wr_n = 0;
    pdca_row_t rows[8] = '{'{8'h08, 32'h2000_0003, 32'h2000_0003},
        '{8'h0C, 32'h7, 32'h7}, '{8'h10, 32'hFF, 32'h0},
        '{8'h14, 32'h1, 32'h1}, '{8'h18, 32'h2000_0005, 32'h2000_0005},
        '{8'h1C, 32'h6, 32'h6}, '{8'h20, 32'hFF, 32'h0},
        '{8'h3C, 32'hFFFF_FFFF, 32'h0}};
    always #2.5 clk = ~clk;
    pdca_top pdca_top_inst (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .ext_req, .ext_done, .ext_err, .ext_rdata,
        .ram_req, .ram_ready, .ram_rdata, .rd_data, .rd_valid, .rd_ready,
        .wr_data, .wr_valid, .wr_ready, .wr_end);
    pdca_ram_model pdca_ram_model_inst (.clk, .slow, .req(ram_req),
        .ready(ram_ready), .rdata(ram_rdata));
    // Peripheral side: sink stalls every other cycle, source counts bytes
    always @(posedge clk) begin
        rd_ready <= ~rd_ready;
        if (rd_valid && rd_ready) rd_q.push_back(rd_data);
        if (wr_valid && wr_ready) begin
            wr_n <= wr_n + 1;
            wr_data <= wr_data + 8'h01;
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] g, e, input string m);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t %s: got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rreg
    task automatic wait_st(input int b);
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 300 && !s[b]; i++) rreg(8'h04, s);
        chk(s[b], 1'b1, "status bit");
    endtask : wait_st
    task automatic ext_acc(input bit m, we, input logic [31:0] a,
        input logic [7:0] d, output logic [1:0] st, output logic [7:0] r);
        @(posedge clk);
        ext_req[m] <= '{1'b1, we, a, d};
        st = 2'b00;
        for (int i = 0; i < 100 && st == 2'b00; i++) begin
            @(posedge clk);
            #1 st = {ext_err[m], ext_done[m]};
        end
        r = ext_rdata[m];
        @(posedge clk);
        ext_req[m].valid <= 1'b0;
    endtask : ext_acc
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            rreg(rows[i].a, v);
            chk(v, 32'h0, "reset value");
        end
        foreach (rows[i]) begin
            wreg(rows[i].a, rows[i].d);
            rreg(rows[i].a, v);
            chk(v, rows[i].e, "register row");
        end
        $display("registers done");
        wreg(8'h08, 32'h2000_0001);
        wreg(8'h0C, 32'h5);
        repeat (2) begin
            wreg(8'h00, 32'h1);
            wait_st(2);
            wreg(8'h04, 32'h4);
        end
        chk(rd_q.size(), 10, "reader count");
        foreach (rd_q[k]) chk(rd_q[k], (k + 1) ^ 8'hA5, "reader data");
        rreg(8'h10, v);
        chk(v, 32'h5, "reader transferred_byte_count");
        $display("reader list done");
        @(posedge clk);
        {slow, wr_n, wr_data, wr_valid} <= {1'b1, 32'h0, 8'hC0, 1'b1};
        wreg(8'h00, 32'h2);
        wait_st(3);
        chk(wr_n, 6, "memory_write_channel taken");
        for (int i = 0; i < 6; i++) chk(pdca_ram_model_inst.mem[32'h2000_0005 + i],
            8'hC0 + i, "memory_write_channel data");
        chk(pdca_ram_model_inst.mem.exists(32'h2000_000B), 0, "overrun");
        wreg(8'h04, 32'h8);
        @(posedge clk) wr_n <= 0;
        wreg(8'h00, 32'h2);
        wait (wr_n == 3);
        @(posedge clk) {wr_valid, wr_end} <= 2'b01;
        @(posedge clk) wr_end <= 1'b0;
        wait_st(3);
        rreg(8'h20, v);
        chk(v, 32'h3, "early transferred_byte_count");
        $display("memory_write_channel done");
        wreg(8'h08, 32'h0000_1000);
        wreg(8'h14, 32'h0);
        wreg(8'h00, 32'h1);
        wait_st(4);
        ext_acc(0, 0, 32'h0000_1000, 8'h00, s0, x0);
        chk(s0, 2'b10, "flash refused");
        fork
            ext_acc(0, 1, 32'h2000_0100, 8'h3C, s0, x0);
            ext_acc(1, 1, 32'h2000_0101, 8'h5B, s1, x1);
        join
        chk({s0, s1}, 4'h5, "both served");
        ext_acc(1, 0, 32'h2000_0100, 8'h00, s1, x1);
        chk(x1, 8'h3C, "cpu write");
        $display("matrix done");
        stop_test();
    end
endmodule : tb
